// ---- hw/slr_params.svh ----
// Constants for the status indicator and signal contact logic.
`ifndef SLR_PARAMS_SVH
`define SLR_PARAMS_SVH
`define SLR_NUM_PORTS      24
`define SLR_NUM_EVENTS     7
`define SLR_BLINK_PERIOD   32'd200000000
`define SLR_SLOT_SHIFT     4
`define SLR_EV_SUPPLY      0
`define SLR_EV_NOTOP       1
`define SLR_EV_LINK        2
`define SLR_EV_RESERVE     3
`define SLR_EV_SELFTEST    4
`define SLR_EV_RINGCFG     5
`define SLR_EV_TEMP        6
`define SLR_EV_SEL_RESET   7'h77
`define SLR_BAUD           9600
`define SLR_CLK_HZ         200000000
`define SLR_BAUD_DIV       (`SLR_CLK_HZ / `SLR_BAUD)
`define SLR_DATA_BITS      8
`define SLR_STOP_BITS      1
`endif

// ---- hw/slr_pkg.sv ----
// Types for the status indicator and signal contact logic.
package slr_pkg;
  typedef struct packed {
    logic red;
    logic green;
    logic yellow;
  } slr_led_t;
  typedef struct packed {
    logic force_en;
    logic force_open;
  } slr_manual_t;
  typedef enum logic [1:0] {
    SLR_ST_RESET = 2'b00,
    SLR_ST_BOOT  = 2'b01,
    SLR_ST_RUN   = 2'b10
  } slr_phase_t;
endpackage

// ---- hw/slr_top.sv ----
// Status indicator and signal contact logic.
`include "slr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module slr_top #(
  parameter int unsigned BLINK_PERIOD = `SLR_BLINK_PERIOD
) (
  input  wire logic                          CLK_SYS_I,
  input  wire logic                          RESETN_I,
  input  wire logic                          CLK_EN_I,
  input  wire logic                          DUAL_SUPPLY_I,
  input  wire logic                          NEW_RELEASE_I,
  input  wire logic [1:0]                    SUPPLY_OK_I,
  input  wire logic                          STANDBY_EN_I,
  input  wire logic                          RING_MANAGER_ON_I,
  input  wire logic                          RING_PORT_FWD_I,
  input  wire logic                          RING_CFG_ERR_I,
  input  wire logic                          STORE_FAIL_I,
  input  wire logic                          STORE_LOAD_I,
  input  wire logic                          STORE_SAVE_I,
  input  wire logic                          DUP_IP_I,
  input  wire logic                          NOT_OPERATIONAL_I,
  input  wire logic                          RESERVE_LOST_I,
  input  wire logic                          SELFTEST_ERR_I,
  input  wire logic                          TEMP_ERR_I,
  input  wire logic                          RESERVE_MON_EN_I,
  input  wire logic [`SLR_NUM_EVENTS-1:0]    EVENT_SEL_1_I,
  input  wire logic [`SLR_NUM_EVENTS-1:0]    EVENT_SEL_2_I,
  input  wire logic                          SEL_LOAD_I,
  input  wire slr_pkg::slr_manual_t          MANUAL_1_I,
  input  wire slr_pkg::slr_manual_t          MANUAL_2_I,
  input  wire logic [`SLR_NUM_PORTS-1:0]     LINK_MASK_I,
  input  wire logic                          LINK_MASK_LOAD_I,
  input  wire logic                          BOOTING_I,
  input  wire logic [3:0]                    BOOT_STEP_I,
  input  wire logic [`SLR_NUM_PORTS-1:0]     PORT_LINK_I,
  input  wire logic [`SLR_NUM_PORTS-1:0]     PORT_STANDBY_I,
  input  wire logic [`SLR_NUM_PORTS-1:0]     PORT_DISABLED_I,
  input  wire logic [`SLR_NUM_PORTS-1:0]     PORT_RX_I,
  output var  slr_pkg::slr_led_t             SUPPLY_LED_O,
  output var  slr_pkg::slr_led_t             STANDBY_LED_O,
  output var  slr_pkg::slr_led_t             RING_MANAGER_LED_O,
  output var  slr_pkg::slr_led_t             FAULT_LED_O,
  output var  slr_pkg::slr_led_t             RELAY_ONE_INDICATOR_O,
  output var  slr_pkg::slr_led_t             RELAY_TWO_INDICATOR_O,
  output logic [`SLR_NUM_PORTS-1:0]          LINK_GREEN_O,
  output logic [`SLR_NUM_PORTS-1:0]          LINK_YELLOW_O,
  output logic                               CONTACT_1_CLOSED_O,
  output logic                               CONTACT_2_CLOSED_O,
  output logic [31:0]                        CONSOLE_BAUD_DIV_O,
  output logic [7:0]                         CONSOLE_FORMAT_O
);

  // Synchronised copies of every status input except the manual overrides, event selections and link mask.
  localparam int NS = 20 + 4 + 4 * `SLR_NUM_PORTS;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  assign raw = {DUAL_SUPPLY_I, NEW_RELEASE_I, SUPPLY_OK_I, STANDBY_EN_I, RING_MANAGER_ON_I,
                RING_PORT_FWD_I, RING_CFG_ERR_I, STORE_FAIL_I, STORE_LOAD_I, STORE_SAVE_I,
                DUP_IP_I, NOT_OPERATIONAL_I, RESERVE_LOST_I, SELFTEST_ERR_I, TEMP_ERR_I,
                RESERVE_MON_EN_I, SEL_LOAD_I, LINK_MASK_LOAD_I, BOOTING_I, BOOT_STEP_I,
                PORT_LINK_I, PORT_STANDBY_I, PORT_DISABLED_I, PORT_RX_I};

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else if (CLK_EN_I)
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic                       dual, newrel, stby, ring_on, ring_fwd, ring_err, st_fail;
  logic                       st_load, st_save, dup_ip, notop, res_lost, st_err, temp_err;
  logic                       res_mon, sel_load, mask_load, booting;
  logic [1:0]                 sup_ok;
  logic [3:0]                 boot_step;
  logic [`SLR_NUM_PORTS-1:0]  p_link;
  logic [`SLR_NUM_PORTS-1:0]  p_stby;
  logic [`SLR_NUM_PORTS-1:0]  p_dis;
  logic [`SLR_NUM_PORTS-1:0]  p_rx;
  assign {dual, newrel, sup_ok, stby, ring_on, ring_fwd, ring_err, st_fail, st_load, st_save,
          dup_ip, notop, res_lost, st_err, temp_err, res_mon, sel_load, mask_load,
          booting, boot_step, p_link, p_stby, p_dis, p_rx} = s2_q;

  // Shared blink period split into 16 slots.
  logic [31:0] blink_cnt_q;
  logic [3:0]  slot;
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
      blink_cnt_q <= '0;
    else if (CLK_EN_I)
      blink_cnt_q <= (blink_cnt_q >= BLINK_PERIOD - 1) ? 32'h0000_0000 : blink_cnt_q + 32'h0000_0001;
  end
  always_comb
  begin
    slot = 4'h0;
    for (int i = 0; i < 16; i++)
      if (blink_cnt_q >= 32'((BLINK_PERIOD / 16) * i))
        slot = 4'(i);
  end

  // N flashes per period: flash k lit in even slot 2k for k below N.
  logic flash1;
  logic flash2;
  logic flash3;
  logic flash4;
  logic half;
  assign flash1 = (slot == 4'h0);
  assign flash2 = !slot[0] && (slot[3:1] < 3'd2);
  assign flash3 = !slot[0] && (slot[3:1] < 3'd3);
  assign flash4 = !slot[0] && (slot[3:1] < 3'd4);
  assign half   = !slot[3];

  // Event selection and link mask, loaded by management strobes.
  logic [`SLR_NUM_EVENTS-1:0] sel1_q;
  logic [`SLR_NUM_EVENTS-1:0] sel2_q;
  logic [`SLR_NUM_PORTS-1:0]  mask_q;
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      sel1_q <= 7'(`SLR_EV_SEL_RESET);
      sel2_q <= 7'(`SLR_EV_SEL_RESET);
      mask_q <= '0;
    end
    else if (CLK_EN_I)
    begin
      if (sel_load)
      begin
        sel1_q <= EVENT_SEL_1_I;
        sel2_q <= EVENT_SEL_2_I;
      end
      if (mask_load)
        mask_q <= LINK_MASK_I;
    end
  end

  // Collect events.
  logic [`SLR_NUM_EVENTS-1:0] ev1;
  logic [`SLR_NUM_EVENTS-1:0] ev2;
  logic                       link_loss;
  logic                       reserve_ev;
  assign link_loss  = |(mask_q & ~p_link & ~p_dis);
  assign reserve_ev = ring_on && res_mon && res_lost;
  always_comb
  begin
    ev1 = '0;
    ev1[`SLR_EV_SUPPLY]   = dual ? !(sup_ok[0]) : !sup_ok[0];
    ev1[`SLR_EV_NOTOP]    = notop;
    ev1[`SLR_EV_LINK]     = link_loss;
    ev1[`SLR_EV_RESERVE]  = reserve_ev;
    ev1[`SLR_EV_SELFTEST] = st_err;
    ev1[`SLR_EV_RINGCFG]  = ring_err;
    ev1[`SLR_EV_TEMP]     = temp_err;
    ev2 = ev1;
    ev2[`SLR_EV_SUPPLY]   = dual && !sup_ok[1];
  end

  // Error state per contact, and contact state with manual override.
  logic err1;
  logic err2;
  logic c1_closed_d;
  logic c2_closed_d;
  assign err1 = |(ev1 & sel1_q);
  assign err2 = dual && |(ev2 & sel2_q);
  assign c1_closed_d = MANUAL_1_I.force_en ? !MANUAL_1_I.force_open : !err1;
  assign c2_closed_d = MANUAL_2_I.force_en ? !MANUAL_2_I.force_open : !err2;

  logic c1_q;
  logic c2_q;
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      c1_q <= 1'b0;
      c2_q <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      c1_q <= c1_closed_d;
      c2_q <= c2_closed_d;
    end
  end
  assign CONTACT_1_CLOSED_O = c1_q;
  assign CONTACT_2_CLOSED_O = c2_q;

  // Console settings exported to the serial block.
  assign CONSOLE_BAUD_DIV_O = 32'(`SLR_BAUD_DIV);
  assign CONSOLE_FORMAT_O   = {2'b00, 4'(`SLR_DATA_BITS), 2'(`SLR_STOP_BITS)};

  // Device indicators.
  slr_pkg::slr_led_t sup_d;
  slr_pkg::slr_led_t sb_d;
  slr_pkg::slr_led_t ring_d;
  slr_pkg::slr_led_t flt_d;
  slr_pkg::slr_led_t rel1_d;
  slr_pkg::slr_led_t rel2_d;
  always_comb
  begin
    sup_d = '0;
    if (dual)
    begin
      sup_d.green  = &sup_ok;
      sup_d.yellow = ^sup_ok;
    end
    else
      sup_d.green  = sup_ok[0];
    sb_d = '0;
    sb_d.green = stby;
    ring_d = '0;
    if (ring_on)
    begin
      ring_d.green  = !ring_fwd && (!ring_err || half);
      ring_d.yellow = ring_fwd && (!ring_err || half);
    end
    if (st_fail)
    begin
      ring_d = '0;
      sb_d = '0;
      ring_d.green = half;
      sb_d.green = !half;
    end
    else if (st_load || st_save)
    begin
      ring_d = '0;
      sb_d = '0;
      ring_d.green = st_load ? flash2 : flash1;
      sb_d.green = st_load ? flash2 : flash1;
    end
    flt_d = '0;
    flt_d.red = err1;
    if (newrel && dup_ip)
      flt_d.red = flash4;
    rel1_d = '0;
    rel2_d = '0;
    if (newrel)
    begin
      rel1_d.yellow = !c1_closed_d;
      rel2_d.yellow = dual && !c2_closed_d;
    end
    else
    begin
      rel1_d.yellow = MANUAL_1_I.force_en && !MANUAL_1_I.force_open;
      rel2_d.yellow = dual && MANUAL_2_I.force_en && !MANUAL_2_I.force_open;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      SUPPLY_LED_O          <= '0;
      STANDBY_LED_O         <= '0;
      RING_MANAGER_LED_O    <= '0;
      FAULT_LED_O           <= '0;
      RELAY_ONE_INDICATOR_O <= '0;
      RELAY_TWO_INDICATOR_O <= '0;
    end
    else if (CLK_EN_I)
    begin
      SUPPLY_LED_O          <= sup_d;
      STANDBY_LED_O         <= sb_d;
      RING_MANAGER_LED_O    <= ring_d;
      FAULT_LED_O           <= flt_d;
      RELAY_ONE_INDICATOR_O <= rel1_d;
      RELAY_TWO_INDICATOR_O <= rel2_d;
    end
  end

  // Port link indicators; boot shows a running bar of the boot step.
  for (genvar p = 0; p < `SLR_NUM_PORTS; p++)
  begin : g_port
    logic g_d;
    logic y_d;
    always_comb
    begin
      g_d = 1'b0;
      y_d = 1'b0;
      if (booting)
        g_d = (5'(p) <= {1'b0, boot_step});
      else if (p_dis[p])
        g_d = flash3;
      else if (p_stby[p])
        g_d = flash1;
      else if (p_link[p])
      begin
        y_d = p_rx[p] && half;
        g_d = !y_d;
      end
    end
    always_ff @(posedge CLK_SYS_I)
    begin
      if (!RESETN_I)
      begin
        LINK_GREEN_O[p]  <= 1'b0;
        LINK_YELLOW_O[p] <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
        LINK_GREEN_O[p]  <= g_d;
        LINK_YELLOW_O[p] <= y_d;
      end
    end
  end

  // Checks.
  property p_supply_dual;
    @(posedge CLK_SYS_I) disable iff (!RESETN_I)
    CLK_EN_I && dual && (&sup_ok) |=> SUPPLY_LED_O.green && !SUPPLY_LED_O.yellow;
  endproperty
  a_supply_dual: assert property (p_supply_dual) else $error("Supply led not green.");

  property p_supply_single;
    @(posedge CLK_SYS_I) disable iff (!RESETN_I)
    CLK_EN_I && !dual |=> SUPPLY_LED_O.green == $past(sup_ok[0]);
  endproperty
  a_supply_single: assert property (p_supply_single) else $error("Single supply led wrong.");

  property p_contact_err;
    @(posedge CLK_SYS_I) disable iff (!RESETN_I)
    CLK_EN_I && err1 && !MANUAL_1_I.force_en |=> !CONTACT_1_CLOSED_O;
  endproperty
  a_contact_err: assert property (p_contact_err) else $error("Contact stayed closed.");

  property p_manual;
    @(posedge CLK_SYS_I) disable iff (!RESETN_I)
    CLK_EN_I && MANUAL_1_I.force_en |=> CONTACT_1_CLOSED_O == !$past(MANUAL_1_I.force_open);
  endproperty
  a_manual: assert property (p_manual) else $error("Manual contact ignored.");

  property p_fault_follows;
    @(posedge CLK_SYS_I) disable iff (!RESETN_I)
    CLK_EN_I && !(newrel && dup_ip) |=> FAULT_LED_O.red == $past(err1);
  endproperty
  a_fault_follows: assert property (p_fault_follows) else $error("Fault led wrong.");

  property p_unselected;
    @(posedge CLK_SYS_I) disable iff (!RESETN_I)
    CLK_EN_I && !MANUAL_1_I.force_en && ((ev1 & sel1_q) == '0) |=> CONTACT_1_CLOSED_O;
  endproperty
  a_unselected: assert property (p_unselected) else $error("Unselected event opened.");

  property p_standby;
    @(posedge CLK_SYS_I) disable iff (!RESETN_I)
    CLK_EN_I && !st_fail && !st_load && !st_save |=> STANDBY_LED_O.green == $past(stby);
  endproperty
  a_standby: assert property (p_standby) else $error("Standby led wrong.");

  property p_mask_reset;
    @(posedge CLK_SYS_I)
    !RESETN_I |=> mask_q == '0;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("Link mask not cleared.");

endmodule
`default_nettype wire

// ---- sim/slr_panel_model.sv ----
// Front panel and alarm loop model: loop current and a flash counter.
`timescale 1ns/1ps
`default_nettype none
module slr_panel_model (
  input  wire logic       clk_i,
  input  wire logic       clear_i,
  input  wire logic       lamp_i,
  input  wire logic       contact_1_closed_i,
  input  wire logic       contact_2_closed_i,
  output logic            loop_1_ok_o,
  output logic            loop_2_ok_o,
  output logic [7:0]      rises_o
);
  logic lamp_q;
  // A closed-circuit loop carries current only while its contact is closed.
  assign loop_1_ok_o = contact_1_closed_i;
  assign loop_2_ok_o = contact_2_closed_i;
  // Counts flashes of the watched lamp since the last clear.
  always_ff @(posedge clk_i)
  begin
    lamp_q <= lamp_i;
    if (clear_i)
      rises_o <= 8'h00;
    else if (lamp_i && !lamp_q)
      rises_o <= rises_o + 8'h01;
  end
endmodule
`default_nettype wire

// ---- sim/test_status_led_and_fault_relay_logic.sv ----
// Self-checking bench for the status indicator and signal contact logic.
`include "slr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_status_led_and_fault_relay_logic;
  localparam int BP = 64;
  logic clk, rst_n, dual, nrel, stby, ring_on, ring_fwd, ring_err, s_fail, s_load, s_save, dup;
  logic en;
  logic notop, res_lost, selft, temp, res_mon, sel_ld, lm_ld, boot, clr, lamp, c1, c2, l1, l2;
  logic [1:0] sup;
  logic [6:0] sel1, sel2;
  logic [3:0] bstep;
  logic [23:0] lmask, plink, pstby, pdis, prx, lg, ly;
  logic [31:0] bdiv;
  logic [7:0] fmt, rises;
  slr_pkg::slr_manual_t man1, man2;
  slr_pkg::slr_led_t sup_led, stby_led, ring_led, flt_led, rel1_led, rel2_led;
  int sel, cyc, n_mismatch, comparisons;

  slr_top #(.BLINK_PERIOD(BP)) slr_top_inst (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .CLK_EN_I(en), .DUAL_SUPPLY_I(dual),
    .NEW_RELEASE_I(nrel), .SUPPLY_OK_I(sup), .STANDBY_EN_I(stby),
    .RING_MANAGER_ON_I(ring_on), .RING_PORT_FWD_I(ring_fwd), .RING_CFG_ERR_I(ring_err),
    .STORE_FAIL_I(s_fail), .STORE_LOAD_I(s_load), .STORE_SAVE_I(s_save), .DUP_IP_I(dup),
    .NOT_OPERATIONAL_I(notop), .RESERVE_LOST_I(res_lost), .SELFTEST_ERR_I(selft),
    .TEMP_ERR_I(temp), .RESERVE_MON_EN_I(res_mon), .EVENT_SEL_1_I(sel1),
    .EVENT_SEL_2_I(sel2), .SEL_LOAD_I(sel_ld), .MANUAL_1_I(man1), .MANUAL_2_I(man2),
    .LINK_MASK_I(lmask), .LINK_MASK_LOAD_I(lm_ld), .BOOTING_I(boot), .BOOT_STEP_I(bstep),
    .PORT_LINK_I(plink), .PORT_STANDBY_I(pstby), .PORT_DISABLED_I(pdis), .PORT_RX_I(prx),
    .SUPPLY_LED_O(sup_led), .STANDBY_LED_O(stby_led), .RING_MANAGER_LED_O(ring_led),
    .FAULT_LED_O(flt_led), .RELAY_ONE_INDICATOR_O(rel1_led), .RELAY_TWO_INDICATOR_O(rel2_led),
    .LINK_GREEN_O(lg), .LINK_YELLOW_O(ly), .CONTACT_1_CLOSED_O(c1),
    .CONTACT_2_CLOSED_O(c2), .CONSOLE_BAUD_DIV_O(bdiv), .CONSOLE_FORMAT_O(fmt)
  );

  slr_panel_model slr_panel_model_inst (
    .clk_i(clk), .clear_i(clr), .lamp_i(lamp), .contact_1_closed_i(c1),
    .contact_2_closed_i(c2), .loop_1_ok_o(l1), .loop_2_ok_o(l2), .rises_o(rises)
  );

  // Picks the lamp whose flashes the panel model counts.
  always_comb
  begin
    case (sel)
      0: lamp = ring_led.green | ring_led.yellow;
      1: lamp = stby_led.green;
      2: lamp = flt_led.red;
      3: lamp = lg[0];
      default: lamp = ly[0];
    endcase
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic settle();
    step(6);
  endtask

  // Counts flashes of one lamp over exactly one blink period.
  task automatic count(input int s);
    sel = s;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(BP);
  endtask

  // Clock enable low must freeze every register, so a status change shows only after release.
  task automatic t_freeze();
    en = 1'b0;
    stby = 1'b1;
    settle();
    check(stby_led, 3'b000);
    en = 1'b1;
    settle();
    check(stby_led, 3'b010);
    stby = 1'b0;
    settle();
  endtask

  task automatic t_supply();
    sup = 2'b01;
    settle();
    check(sup_led, 3'b001);
    check({l1, l2}, 2'b10);
    check(rel2_led, 3'b001);
    sup = 2'b10;
    settle();
    check({l1, l2}, 2'b01);
    sup = 2'b00;
    settle();
    check(sup_led, 3'b000);
    dual = 1'b0;
    sup = 2'b01;
    settle();
    check(sup_led, 3'b010);
    sup = 2'b00;
    settle();
    check(sup_led, 3'b000);
    dual = 1'b1;
    sup = 2'b11;
    settle();
    check(sup_led, 3'b010);
  endtask

  task automatic t_ring();
    stby = 1'b1;
    settle();
    check(stby_led, 3'b010);
    stby = 1'b0;
    settle();
    check(stby_led, 3'b000);
    check(ring_led, 3'b000);
    ring_on = 1'b1;
    settle();
    check(ring_led, 3'b010);
    ring_fwd = 1'b1;
    settle();
    check(ring_led, 3'b001);
    ring_fwd = 1'b0;
    ring_err = 1'b1;
    settle();
    check(l1, 1'b0);
    count(0);
    check(rises > 0, 1'b1);
    ring_err = 1'b0;
    settle();
    check(l1, 1'b1);
  endtask

  task automatic t_events();
    for (int k = 0; k < 3; k++)
    begin
      {notop, selft, temp} = 3'b100 >> k;
      settle();
      check({l1, flt_led.red, rel1_led.yellow}, 3'b011);
      {notop, selft, temp} = 3'b000;
      settle();
      check({l1, flt_led.red, rel1_led.yellow}, 3'b100);
    end
  endtask

  task automatic t_select();
    res_lost = 1'b1;
    res_mon = 1'b1;
    settle();
    check(l1, 1'b1);
    sel1 = 7'h7F;
    sel_ld = 1'b1;
    settle();
    check(l1, 1'b0);
    res_lost = 1'b0;
    sel1 = 7'h6F;
    settle();
    sel_ld = 1'b0;
    selft = 1'b1;
    settle();
    check({l1, l2}, 2'b10);
    selft = 1'b0;
    sel1 = 7'h77;
    sel_ld = 1'b1;
    settle();
    sel_ld = 1'b0;
    ring_on = 1'b0;
    res_mon = 1'b0;
    plink[0] = 1'b0;
    settle();
    check(l1, 1'b1);
    lm_ld = 1'b1;
    settle();
    lm_ld = 1'b0;
    check({l1, lg[0]}, 2'b00);
    plink[0] = 1'b1;
    settle();
    check({l1, lg[0]}, 2'b11);
  endtask

  task automatic t_manual();
    man1 = 2'b11;
    step(2);
    check(l1, 1'b0);
    selft = 1'b1;
    man1 = 2'b10;
    settle();
    check({l1, flt_led.red}, 2'b11);
    selft = 1'b0;
    nrel = 1'b0;
    settle();
    check(rel1_led.yellow, 1'b1);
    man1 = 2'b11;
    settle();
    check(rel1_led.yellow, 1'b0);
    dup = 1'b1;
    count(2);
    check(rises, 8'h00);
    dup = 1'b0;
    man1 = 2'b00;
    nrel = 1'b1;
    settle();
  endtask

  task automatic t_flash();
    int both;
    both = 0;
    s_load = 1'b1;
    settle();
    count(0);
    check(rises, 8'h02);
    count(1);
    check(rises, 8'h02);
    s_load = 1'b0;
    s_save = 1'b1;
    settle();
    count(1);
    check(rises, 8'h01);
    s_save = 1'b0;
    s_fail = 1'b1;
    settle();
    repeat (BP)
    begin
      step(1);
      if ((ring_led.green | ring_led.yellow) && stby_led.green)
        both++;
    end
    check(both, 0);
    count(0);
    check(rises > 0, 1'b1);
    s_fail = 1'b0;
    dup = 1'b1;
    settle();
    count(2);
    check(rises, 8'h04);
    dup = 1'b0;
    pdis[0] = 1'b1;
    settle();
    count(3);
    check(rises, 8'h03);
    pdis[0] = 1'b0;
    pstby[0] = 1'b1;
    settle();
    count(3);
    check(rises, 8'h01);
    pstby[0] = 1'b0;
    prx[0] = 1'b1;
    settle();
    count(4);
    check(rises > 0, 1'b1);
    prx[0] = 1'b0;
    boot = 1'b1;
    bstep = 4'h2;
    settle();
    check(lg[3:0], 4'h7);
  endtask

  initial
  begin
    {rst_n, stby, ring_on, ring_fwd, ring_err, s_fail, s_load, s_save, dup} = '0;
    {notop, res_lost, selft, temp, res_mon, sel_ld, lm_ld, boot, clr} = '0;
    {dual, nrel, sup, sel1, sel2, lmask} = {2'b11, 2'b11, 7'h77, 7'h77, 24'h00_0001};
    {man1, man2, bstep, pstby, pdis, prx} = '0;
    plink = '1;
    en = 1'b1;
    sel = 0;
    cyc = 0;
    n_mismatch = 0;
    comparisons = 0;
    step(3);
    check(c1, 1'b0);
    step(2);
    rst_n = 1'b1;
    settle();
    check(bdiv, 32'h0000_5161);
    check(fmt, 8'h21);
    check({l1, l2}, 2'b11);
    t_freeze();
    t_supply();
    t_ring();
    t_events();
    t_select();
    t_manual();
    t_flash();
    close_out();
  end
endmodule
`default_nettype wire
